/* File: verilog/ffsc_decode.v */
// Flag status register and opcode decoder of a serial flash, sampled on the system clock
`timescale 1ns/1ps
`include "ffsc_map.vh"
// Behaviour
// - Flag bit 7 is 1 when controller ready, 0 during program/erase cycles.
// - Flag bit 6 is 1 while erase suspended or suspend pending.
// - Flag bit 5 sets on erase failure or protection error.
// - Flag bit 4 sets on program failure, including forbidden 0-to-1 accelerated pattern.
// - Flag bit 3 sets on invalid accelerator supply during program or erase; default 1.
// - Flag bit 2 is 1 while program suspended or suspend pending.
// - Flag bit 1 sets when program hits protected sector or locked OTP.
// - Flag bit 0 shows address mode: 0 three-byte, 1 four-byte.
// - All flag bits volatile and returned by a register read command.
// - Status bits 7, 6, 2, 0 update automatically as operations start and end.
// - Error bits 5, 4, 3, 1 stay set until clear-flag command.
// - New program or erase while an error flag is set is itself an error.
// - Ready bit tracks program and erase cycles only, not register writes.
// - Wide ID only in dual/quad; standard ID 9E/9F only in extended.
// - Dual protocol decodes dual I/O fast read from 0B, 3B or BB.
// - Quad protocol decodes quad I/O fast read from 0B, 6B or EB.
// - DTR quad I/O reads 0D/6D/ED in extended and quad, stream until deselect.
// - Dual-output DTR read 3D supported in extended and dual, rejected in quad.
// - Dedicated 4-byte reads always take four address bytes.
// - 4-byte dual I/O read BC accepted in extended and dual only.
// - Opcode 70 reads flag register repeatedly in every protocol.
// - Opcode 50 clears all error flag bits.
// - Fast reads default to 8 dummy clocks, 10 in quad; configurable.
module ffsc_decode #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire clk,
    input wire rst,
    input wire spi_cs_n,
    input wire spi_sck,
    input wire spi_mosi,
    output reg spi_miso,
    output reg spi_miso_oe,
    input wire [1:0] proto_sel,
    input wire [3:0] dummy_cfg,
    input wire dummy_cfg_valid,
    input wire op_prog_busy,
    input wire op_erase_busy,
    input wire op_reg_busy,
    input wire erase_susp,
    input wire prog_susp,
    input wire erase_fail,
    input wire prog_fail,
    input wire accel_supply_input_bad,
    input wire prot_fail,
    input wire addr4_mode,
    output reg [7:0] cmd_code,
    output reg cmd_valid,
    output reg cmd_addr4,
    output reg [3:0] cmd_dummy,
    output reg cmd_dtr_stream,
    output reg cmd_ignored,
    output reg flag_error_op,
    output reg soft_reset,
    output reg [7:0] program_erase_flags
);
    localparam ST_IDLE = 3'b001;
    localparam ST_OPC = 3'b010;
    localparam ST_READ = 3'b100;
    reg [2:0] st_reg;
    reg [2:0] st_next;
    reg cs_m_reg, cs_s_reg, sck_m_reg, sck_s_reg, sck_d_reg, mosi_m_reg, mosi_s_reg;
    reg [7:0] shift_reg;
    reg [2:0] bit_reg;
    reg [7:0] tx_reg;
    reg [2:0] tx_cnt_reg;
    reg rst_armed_reg;
    reg accel_seen_reg;
    reg rd_flags_reg;
    wire ff_clr;
    wire sck_rise;
    wire sck_fall;
    wire [7:0] opc;
    wire in_ext;
    wire in_dual;
    wire in_quad;
    wire any_err;
    wire [7:0] ff_out;
    wire ff_valid;
    wire ff_in_ready;
    reg ff_push;
    reg ff_pop;
    reg ok;
    reg four;
    reg fast;
    reg dtr;
    assign sck_rise = sck_s_reg && !sck_d_reg;
    assign sck_fall = !sck_s_reg && sck_d_reg;
    assign opc = {shift_reg[6:0], mosi_s_reg};
    assign in_ext = (proto_sel == `FFSC_PROTO_EXT);
    assign in_dual = (proto_sel == `FFSC_PROTO_DUAL);
    assign in_quad = (proto_sel == `FFSC_PROTO_QUAD);
    // Drop leftover snapshots between frames so a new read starts fresh
    assign ff_clr = rst | (st_reg == ST_IDLE);
    assign any_err = program_erase_flags[`FFSC_BIT_ERS_ERR] | program_erase_flags[`FFSC_BIT_PRG_ERR] |
                     program_erase_flags[`FFSC_BIT_PROT_ERR] | accel_seen_reg;
    // Buffers flag snapshots toward the serial output so the shifter never stalls the sampler
    ffsc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .clk(clk),
        .rst(ff_clr),
        .in_data(program_erase_flags),
        .in_valid(ff_push),
        .in_ready(ff_in_ready),
        .out_data(ff_out),
        .out_valid(ff_valid),
        .out_ready(ff_pop)
    );
    // Protocol support decode for each opcode
    always @* begin
        ok = 1'b0;
        four = addr4_mode;
        fast = 1'b0;
        dtr = 1'b0;
        case (opc)
            `FFSC_OP_RST_EN, `FFSC_OP_RST_MEM, `FFSC_OP_RD_FLAGS, `FFSC_OP_CLR_FLAGS: begin
                ok = 1'b1;
            end
            `FFSC_OP_ID_9E, `FFSC_OP_ID_9F: begin
                ok = in_ext;
            end
            `FFSC_OP_WIDE_ID: begin
                ok = in_dual | in_quad;
            end
            `FFSC_OP_READ: begin
                ok = in_ext;
            end
            `FFSC_OP_FAST: begin
                ok = 1'b1;
                fast = 1'b1;
            end
            `FFSC_OP_DOFR, `FFSC_OP_DIOFR: begin
                ok = in_ext | in_dual;
                fast = 1'b1;
            end
            `FFSC_OP_QOFR, `FFSC_OP_QIOFR: begin
                ok = in_ext | in_quad;
                fast = 1'b1;
            end
            `FFSC_OP_FAST_DTR, `FFSC_OP_QO_DTR, `FFSC_OP_QIO_DTR: begin
                ok = (opc == `FFSC_OP_FAST_DTR) ? 1'b1 : (in_ext | in_quad);
                fast = 1'b1;
                dtr = 1'b1;
            end
            `FFSC_OP_DO_DTR, `FFSC_OP_DIO_DTR: begin
                ok = in_ext | in_dual;
                fast = 1'b1;
                dtr = 1'b1;
            end
            `FFSC_OP_READ4: begin
                ok = 1'b1;
                four = 1'b1;
            end
            `FFSC_OP_FAST4: begin
                ok = 1'b1;
                four = 1'b1;
                fast = 1'b1;
            end
            `FFSC_OP_DO4, `FFSC_OP_DIO4: begin
                ok = in_ext | in_dual;
                four = 1'b1;
                fast = 1'b1;
            end
            `FFSC_OP_QO4, `FFSC_OP_QIO4: begin
                ok = in_ext | in_quad;
                four = 1'b1;
                fast = 1'b1;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
    end
    always @* begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE: begin
                if (!cs_s_reg) begin
                    st_next = ST_OPC;
                end
            end
            ST_OPC: begin
                if (cs_s_reg) begin
                    st_next = ST_IDLE;
                end else if (sck_rise && bit_reg == 3'h7) begin
                    st_next = ST_READ;
                end
            end
            ST_READ: begin
                if (cs_s_reg) begin
                    st_next = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end
    always @(posedge clk) begin
        if (rst) begin
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            sck_m_reg <= 1'b0;
            sck_s_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            mosi_m_reg <= 1'b0;
            mosi_s_reg <= 1'b0;
        end else begin
            cs_m_reg <= spi_cs_n;
            cs_s_reg <= cs_m_reg;
            sck_m_reg <= spi_sck;
            sck_s_reg <= sck_m_reg;
            sck_d_reg <= sck_s_reg;
            mosi_m_reg <= spi_mosi;
            mosi_s_reg <= mosi_m_reg;
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            st_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 3'h0;
            tx_reg <= 8'h00;
            tx_cnt_reg <= 3'h0;
            rst_armed_reg <= 1'b0;
            accel_seen_reg <= 1'b1;
            rd_flags_reg <= 1'b0;
            cmd_code <= 8'h00;
            cmd_valid <= 1'b0;
            cmd_addr4 <= 1'b0;
            cmd_dummy <= `FFSC_DUMMY_DEF;
            cmd_dtr_stream <= 1'b0;
            cmd_ignored <= 1'b0;
            flag_error_op <= 1'b0;
            soft_reset <= 1'b0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
            ff_push <= 1'b0;
            ff_pop <= 1'b0;
            program_erase_flags <= `FFSC_FLAGS_RESET;
        end else begin
            st_reg <= st_next;
            cmd_valid <= 1'b0;
            cmd_ignored <= 1'b0;
            soft_reset <= 1'b0;
            flag_error_op <= 1'b0;
            ff_push <= 1'b0;
            ff_pop <= 1'b0;
            // Status bits follow the operation engine directly
            program_erase_flags[`FFSC_BIT_READY] <= !(op_prog_busy | op_erase_busy);
            program_erase_flags[`FFSC_BIT_ERS_SUSP] <= erase_susp;
            program_erase_flags[`FFSC_BIT_PRG_SUSP] <= prog_susp;
            program_erase_flags[`FFSC_BIT_ADDR4] <= addr4_mode;
            if (cs_s_reg) begin
                bit_reg <= 3'h0;
                spi_miso_oe <= 1'b0;
                tx_cnt_reg <= 3'h0;
                rd_flags_reg <= 1'b0;
            end
            if (st_reg == ST_OPC && sck_rise && !cs_s_reg) begin
                shift_reg <= opc;
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    cmd_valid <= ok;
                    cmd_ignored <= !ok;
                    rd_flags_reg <= (opc == `FFSC_OP_RD_FLAGS);
                    // Refused opcodes leave every decoded output as it was
                    if (ok) begin
                        cmd_code <= opc;
                        cmd_addr4 <= four;
                        cmd_dummy <= !fast ? 4'h0 : dummy_cfg_valid ? dummy_cfg :
                                     in_quad ? `FFSC_DUMMY_QUAD : `FFSC_DUMMY_DEF;
                        cmd_dtr_stream <= dtr;
                    end
                    rst_armed_reg <= (opc == `FFSC_OP_RST_EN);
                    soft_reset <= rst_armed_reg && (opc == `FFSC_OP_RST_MEM);
                    if (opc == `FFSC_OP_RD_FLAGS) begin
                        ff_push <= ff_in_ready;
                    end
                end
            end
            if (st_reg == ST_READ && rd_flags_reg && !cs_s_reg) begin
                if (sck_fall) begin
                    if (tx_cnt_reg == 3'h0) begin
                        tx_reg <= {ff_out[6:0], 1'b0};
                        spi_miso <= ff_out[7];
                        ff_pop <= ff_valid;
                        ff_push <= ff_in_ready;
                    end else begin
                        spi_miso <= tx_reg[7];
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end
                    spi_miso_oe <= 1'b1;
                    tx_cnt_reg <= tx_cnt_reg + 3'h1;
                end
            end
            // Error bits: set wins over clear
            if (sck_rise && st_reg == ST_OPC && bit_reg == 3'h7 && opc == `FFSC_OP_CLR_FLAGS) begin
                program_erase_flags[`FFSC_BIT_ERS_ERR] <= erase_fail;
                program_erase_flags[`FFSC_BIT_PRG_ERR] <= prog_fail;
                program_erase_flags[`FFSC_BIT_PROT_ERR] <= prot_fail;
                accel_seen_reg <= accel_supply_input_bad & (op_prog_busy | op_erase_busy);
                program_erase_flags[`FFSC_BIT_ACCEL_ERR] <= accel_supply_input_bad &
                                                            (op_prog_busy | op_erase_busy);
            end else begin
                if (erase_fail) begin
                    program_erase_flags[`FFSC_BIT_ERS_ERR] <= 1'b1;
                end
                if (prog_fail) begin
                    program_erase_flags[`FFSC_BIT_PRG_ERR] <= 1'b1;
                end
                if (prot_fail) begin
                    program_erase_flags[`FFSC_BIT_PROT_ERR] <= 1'b1;
                end
                if (accel_supply_input_bad && (op_prog_busy | op_erase_busy)) begin
                    program_erase_flags[`FFSC_BIT_ACCEL_ERR] <= 1'b1;
                    accel_seen_reg <= 1'b1;
                end
            end
            if (op_prog_busy | op_erase_busy | op_reg_busy) begin
                flag_error_op <= any_err & (op_prog_busy | op_erase_busy) &
                                 !program_erase_flags[`FFSC_BIT_READY];
            end
        end
    end
endmodule // ffsc_decode

/* File: verilog/ffsc_map.vh */
// Constants for the flag status and command decode block
`ifndef FFSC_MAP_VH
`define FFSC_MAP_VH
`define FFSC_BIT_READY 7
`define FFSC_BIT_ERS_SUSP 6
`define FFSC_BIT_ERS_ERR 5
`define FFSC_BIT_PRG_ERR 4
`define FFSC_BIT_ACCEL_ERR 3
`define FFSC_BIT_PRG_SUSP 2
`define FFSC_BIT_PROT_ERR 1
`define FFSC_BIT_ADDR4 0
`define FFSC_FLAGS_RESET 8'h88
`define FFSC_OP_RST_EN 8'h66
`define FFSC_OP_RST_MEM 8'h99
`define FFSC_OP_ID_9E 8'h9E
`define FFSC_OP_ID_9F 8'h9F
`define FFSC_OP_WIDE_ID 8'hAF
`define FFSC_OP_READ 8'h03
`define FFSC_OP_FAST 8'h0B
`define FFSC_OP_DOFR 8'h3B
`define FFSC_OP_DIOFR 8'hBB
`define FFSC_OP_QOFR 8'h6B
`define FFSC_OP_QIOFR 8'hEB
`define FFSC_OP_FAST_DTR 8'h0D
`define FFSC_OP_DO_DTR 8'h3D
`define FFSC_OP_DIO_DTR 8'hBD
`define FFSC_OP_QO_DTR 8'h6D
`define FFSC_OP_QIO_DTR 8'hED
`define FFSC_OP_READ4 8'h13
`define FFSC_OP_FAST4 8'h0C
`define FFSC_OP_DO4 8'h3C
`define FFSC_OP_DIO4 8'hBC
`define FFSC_OP_QO4 8'h6C
`define FFSC_OP_QIO4 8'hEC
`define FFSC_OP_RD_FLAGS 8'h70
`define FFSC_OP_CLR_FLAGS 8'h50
`define FFSC_DUMMY_DEF 4'h8
`define FFSC_DUMMY_QUAD 4'hA
`define FFSC_PROTO_EXT 2'h0
`define FFSC_PROTO_DUAL 2'h1
`define FFSC_PROTO_QUAD 2'h2
`endif

/* File: verilog/ffsc_fifo.v */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ffsc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;
    assign in_ready = (cnt_reg != DEPTH);
    assign out_valid = (cnt_reg != 0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
        if (rst) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH-1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH-1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // ffsc_fifo

/* File: bench/ffsc_decode_assertions.sv */
// Port-level assertions for the flag register and opcode decoder
`timescale 1ns/1ps
module ffsc_chk (
    input wire clk,
    input wire rst,
    input wire op_prog_busy,
    input wire op_erase_busy,
    input wire erase_susp,
    input wire prog_susp,
    input wire addr4_mode,
    input wire erase_fail,
    input wire prog_fail,
    input wire prot_fail,
    input wire [7:0] cmd_code,
    input wire cmd_valid,
    input wire cmd_ignored,
    input wire soft_reset,
    input wire spi_miso_oe,
    input wire [7:0] program_erase_flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence busy_run;
        (op_prog_busy || op_erase_busy) [*2];
    endsequence
    sequence idle_run;
        (!op_prog_busy && !op_erase_busy) [*2];
    endsequence
    ready_low_a: assert property (busy_run |=> !program_erase_flags[7]) else $error("ready while busy");
    ready_high_a: assert property (idle_run |=> program_erase_flags[7]) else $error("not ready when idle");
    erase_susp_a: assert property (erase_susp [*2] |=> program_erase_flags[6]) else $error("erase suspend lost");
    prog_susp_a: assert property (!prog_susp [*2] |=> !program_erase_flags[2]) else $error("stale suspend");
    addr_mode_a: assert property (addr4_mode [*2] |=> program_erase_flags[0]) else $error("address mode");
    erase_err_a: assert property (erase_fail |=> program_erase_flags[5]) else $error("erase error missed");
    prog_err_a: assert property (prog_fail |=> program_erase_flags[4]) else $error("program error missed");
    prot_err_a: assert property (prot_fail |=> program_erase_flags[1]) else $error("protection error missed");
    err_hold_a: assert property (((program_erase_flags ^ 8'hFF) & $past(program_erase_flags) & 8'h3A) != 8'h00
        |-> ##[0:2] cmd_code == 8'h50) else $error("error bit fell");
    pulse_once_a: assert property ((cmd_valid || cmd_ignored) |-> !(cmd_valid && cmd_ignored)
        ##1 !(cmd_valid || cmd_ignored)) else $error("decode pulse");
    soft_rst_a: assert property (soft_reset |-> cmd_code == 8'h99) else $error("reset without 99");
    oe_flag_a: assert property (spi_miso_oe |-> cmd_code == 8'h70) else $error("drive outside read");
endmodule // ffsc_chk
bind ffsc_decode ffsc_chk u_chk (.clk(clk), .rst(rst), .op_prog_busy(op_prog_busy), .op_erase_busy(op_erase_busy),
    .erase_susp(erase_susp), .prog_susp(prog_susp), .addr4_mode(addr4_mode), .erase_fail(erase_fail),
    .prog_fail(prog_fail), .prot_fail(prot_fail), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
    .cmd_ignored(cmd_ignored), .soft_reset(soft_reset), .spi_miso_oe(spi_miso_oe),
    .program_erase_flags(program_erase_flags));

/* File: bench/ffsc_host.sv */
// Host controller model driving the serial pins
`timescale 1ns/1ps
module ffsc_host (
    input wire clk,
    input wire spi_miso,
    output reg spi_cs_n,
    output reg spi_sck,
    output reg spi_mosi
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
    end
    // Opcode MSB first, then nrd bytes read back; clock idles low between frames
    task frame(input [7:0] op, input integer nrd, output [15:0] rd);
        integer i;
        begin
            rd = 16'h0000;
            @(posedge clk);
            spi_cs_n <= 1'b0;
            for (i = 0; i < 8 + 8 * nrd; i = i + 1) begin
                spi_mosi <= (i < 8) ? op[7 - i] : ~spi_mosi;
                repeat (4) @(posedge clk);
                spi_sck <= 1'b1;
                repeat (3) @(posedge clk);
                @(negedge clk);
                if (i >= 8) rd = {rd[14:0], spi_miso};
                @(posedge clk);
                spi_sck <= 1'b0;
            end
            repeat (4) @(posedge clk);
            spi_cs_n <= 1'b1;
            spi_mosi <= ~spi_mosi;
        end
    endtask
endmodule // ffsc_host

/* File: bench/tb_top.sv */
// Self-checking bench for the flag register and opcode decoder
`timescale 1ns/1ps
`include "ffsc_map.vh"
module tb_top;
    localparam NT = 29;
    localparam [12*NT-1:0] TAB = {12'h29F, 12'h49F, 12'h89E, 12'h0AF, 12'h6AF, 12'hAAF, 12'h60B, 12'h63B,
        12'h6BB, 12'h8BB, 12'hA6B, 12'hAEB, 12'h4EB, 12'h2ED, 12'hA6D, 12'h4ED, 12'h23D, 12'h63D, 12'h83D,
        12'h3BC, 12'h7BC, 12'h8BC, 12'h313, 12'h30C, 12'h36C, 12'h3EC, 12'hB13, 12'h20B, 12'hA0B};
    reg clk, rst, dcv, pbusy, ebusy, rbusy, esusp, psusp, efail, pfail, abad, pfl, a4;
    reg got_v, got_i, got_sr, got_fe, got_oe;
    reg [1:0] proto;
    reg [3:0] dcfg, exp_err;
    reg [7:0] prev;
    reg [11:0] ent;
    reg [15:0] rd;
    integer err_count, num_checks, i, k;
    wire cs_n, sck, mosi, miso, v, ign, sr, fe, a4o, oe, dtr;
    wire [7:0] code, flags;
    wire [3:0] dum;
    ffsc_decode DUT (.clk(clk), .rst(rst), .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe(oe), .proto_sel(proto), .dummy_cfg(dcfg), .dummy_cfg_valid(dcv), .op_prog_busy(pbusy),
        .op_erase_busy(ebusy), .op_reg_busy(rbusy), .erase_susp(esusp), .prog_susp(psusp), .erase_fail(efail),
        .prog_fail(pfail), .accel_supply_input_bad(abad), .prot_fail(pfl), .addr4_mode(a4), .cmd_code(code),
        .cmd_valid(v), .cmd_addr4(a4o), .cmd_dummy(dum), .cmd_dtr_stream(dtr), .cmd_ignored(ign),
        .flag_error_op(fe), .soft_reset(sr), .program_erase_flags(flags));
    ffsc_host host (.clk(clk), .spi_miso(miso), .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Latch one-cycle pulses so a later check cannot miss them
    always @(posedge clk) begin
        if (v === 1'b1) got_v <= 1'b1;
        if (ign === 1'b1) got_i <= 1'b1;
        if (sr === 1'b1) got_sr <= 1'b1;
        if (fe === 1'b1) got_fe <= 1'b1;
        if (oe === 1'b1) got_oe <= 1'b1;
    end
    function [7:0] exp_flags(input [3:0] e);
        exp_flags = {~(pbusy | ebusy), esusp, e[3:1], psusp, e[0], a4};
    endfunction
    task check(input [15:0] got, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (err_count == 0 && num_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task settle(input integer n);
        begin
            repeat (n) @(posedge clk);
            @(negedge clk);
        end
    endtask
    task send(input [7:0] op, input integer nrd);
        begin
            got_v = 1'b0;
            got_i = 1'b0;
            got_sr = 1'b0;
            got_oe = 1'b0;
            host.frame(op, nrd, rd);
            repeat (4) @(posedge clk);
            if (!(got_v | got_i)) begin
                check(16'h0001, 16'h0000);
                report_and_stop;
            end
        end
    endtask
    initial begin
        rst = 1'b1;
        {dcv, pbusy, ebusy, rbusy, esusp, psusp, efail, pfail, abad, pfl, a4} = 11'h000;
        {got_v, got_i, got_sr, got_fe, got_oe} = 5'h00;
        proto = 2'h0;
        dcfg = 4'h0;
        err_count = 0;
        num_checks = 0;
        exp_err = 4'h2;
        k = $urandom(89);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle(2);
        check(flags, `FFSC_FLAGS_RESET);
        for (i = 0; i < 12; i = i + 1) begin
            k = $urandom;
            @(posedge clk);
            {pbusy, ebusy, rbusy, esusp, psusp, a4} <= k[5:0];
            {efail, pfail, abad, pfl} <= (i % 4 == 1) ? k[9:6] : 4'h0;
            exp_err = exp_err | ((i % 4 == 1) ? k[9:6] : 4'h0);
            @(posedge clk);
            {efail, pfail, abad, pfl} <= 4'h0;
            settle(2);
            check(flags, exp_flags(exp_err));
            if (i % 4 == 3) begin
                send(`FFSC_OP_RD_FLAGS, 2);
                check(rd, {2{exp_flags(exp_err)}});
                check({got_oe, oe}, 2'b10);
            end
        end
        @(posedge clk);
        {pbusy, ebusy, rbusy, esusp, psusp, a4} <= 6'h20;
        got_fe = 1'b0;
        settle(3);
        check(got_fe, 1'b1);
        send(`FFSC_OP_CLR_FLAGS, 0);
        exp_err = 4'h0;
        settle(1);
        check(flags, exp_flags(exp_err));
        got_fe = 1'b0;
        settle(3);
        check(got_fe, 1'b0);
        @(posedge clk);
        pbusy <= 1'b0;
        for (i = 0; i < NT; i = i + 1) begin
            ent = TAB[12 * i +: 12];
            @(posedge clk);
            proto <= ent[11:10];
            prev = code;
            send(ent[7:0], 0);
            check({got_v, got_i}, {ent[9], ~ent[9]});
            check(code, ent[9] ? ent[7:0] : prev);
            if (ent[9]) check(a4o, ent[8]);
            if (ent[9]) check(dtr, ent[3:0] == 4'hD);
            if (ent[7:0] == `FFSC_OP_FAST)
                check(dum, ent[11] ? `FFSC_DUMMY_QUAD : `FFSC_DUMMY_DEF);
        end
        k = $urandom % 15;
        @(posedge clk);
        proto <= `FFSC_PROTO_EXT;
        dcv <= 1'b1;
        dcfg <= k[3:0] + 4'h1;
        send(`FFSC_OP_FAST, 0);
        check(dum, k[3:0] + 4'h1);
        send(`FFSC_OP_RST_EN, 0);
        send(`FFSC_OP_RST_MEM, 0);
        check(got_sr, 1'b1);
        send(`FFSC_OP_RD_FLAGS, 0);
        send(`FFSC_OP_RST_MEM, 0);
        check(got_sr, 1'b0);
        report_and_stop;
    end
endmodule // tb_top
